// File: design/gcm_pkg.sv
/*
  Shared constants, types and register map of the curve and colour-matrix stage.
  Assumes one 40 MHz clock and an AXI4-Lite register bus with 32-bit data.
*/
package gcm_pkg;

  // Widths
  localparam int PIX_W       = 12;
  localparam int COEF_W      = 9;
  localparam int EXP_W       = 18;
  localparam int BLEND_W     = 17;
  localparam int ADDR_W      = 8;
  localparam int LOG_FRAC    = 12;
  localparam int COEF_SHIFT  = 5;
  localparam int BLEND_SHIFT = 16;
  localparam int EXP_SHIFT   = 16;

  // Full-scale brightness per output width
  localparam logic [PIX_W-1:0]   FS_8        = 12'h0ff;
  localparam logic [PIX_W-1:0]   FS_12       = 12'hfff;

  // Exponent is unsigned 2.16 fixed point, so 3ffff is 3.99998
  localparam logic [EXP_W-1:0]   EXP_UNITY   = 18'h10000;
  localparam logic [EXP_W-1:0]   EXP_DISPLAY = 18'h07455;

  // Blend strength, 10000 hex is full effect
  localparam logic [BLEND_W-1:0] BLEND_FULL  = 17'h10000;

  // Coefficient value 32 is unity
  localparam logic [COEF_W-1:0]  COEF_UNITY  = 9'h020;
  localparam logic [COEF_W-1:0]  COEF_ZERO   = 9'h000;
  localparam logic [8:0][COEF_W-1:0] COEF_IDENTITY = {
    COEF_UNITY, COEF_ZERO, COEF_ZERO,
    COEF_ZERO, COEF_UNITY, COEF_ZERO,
    COEF_ZERO, COEF_ZERO, COEF_UNITY};

  // Register byte offsets
  localparam logic [ADDR_W-1:0]  A_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0]  A_ILLUM     = 8'h04;
  localparam logic [ADDR_W-1:0]  A_EXPO      = 8'h08;
  localparam logic [ADDR_W-1:0]  A_BLEND     = 8'h0c;
  localparam logic [ADDR_W-1:0]  A_STATUS    = 8'h10;
  localparam logic [ADDR_W-1:0]  A_PIXCNT    = 8'h14;
  localparam logic [ADDR_W-1:0]  A_COEF0     = 8'h20;
  localparam logic [ADDR_W-1:0]  A_COEF8     = 8'h40;

  // Control register fields
  localparam int CTRL_CURVE_ON   = 0;
  localparam int CTRL_CURVE_USER = 1;
  localparam int CTRL_ENH_ALLOW  = 2;
  localparam int CTRL_RAW_OUT    = 3;
  localparam int CTRL_OUT_12     = 4;
  localparam int CTRL_MTYPE_LSB  = 8;
  localparam logic [1:0] MTYPE_RGB2RGB = 2'h0;

  // Status register fields
  localparam int STAT_BLEND_AVAIL = 0;
  localparam int STAT_MATRIX_ON   = 1;
  localparam int STAT_WB_NEUTRAL  = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ILL_OFF,
    ILL_TUNGSTEN,
    ILL_DAYLIGHT,
    ILL_D6500,
    ILL_CUSTOM
  } gcm_illum_e;

  // c[0] red, c[1] green, c[2] blue
  typedef struct packed {
    logic [2:0][PIX_W-1:0] c;
  } gcm_rgb_s;

  typedef struct packed {
    logic out_12;
    logic raw_out;
    logic enh_allow;
    logic curve_user;
    logic curve_on;
  } gcm_ctrl_s;

endpackage

// File: design/gcm_stage.sv
/*
  Brightness curve and 3x3 colour-correction stage with AXI4-Lite settings.
  Assumes upstream RGB pixels with valid/ready, a downstream sink with
  valid/ready, and a single clock shared with the register bus.
*/
// Functional notes
// - Two curve modes: display and user
// - Display mode uses built-in fixed curve
// - User curve: (x/full)^exponent times full
// - Full scale 255 at 8, 4095 at 12
// - Exponent accepted from zero to 3.99998
// - Exponent one passes brightness unchanged
// - Zero stays zero, full stays full
// - Curve only when enabled; mode picks curve
// - Raw out without permission bypasses matrix
// - Permission allows enhancement on raw output
// - Matrix type is RGB-to-RGB only
// - Illuminant off leaves pixels unaltered
// - Presets load matrix and colour profile
// - Custom uses host coefficients, neutral profile
// - RGB vector times selected 3x3 matrix
// - Blend zero no effect, one full
// - Blend integer 0..65536 maps linearly
// - Blend unavailable when off or custom
// - Coefficients -256..255, 32 is unity
// - Output is weighted sum of inputs
module gcm_stage #(
  parameter logic [8:0][gcm_pkg::COEF_W-1:0] PRESET_TUNGSTEN = gcm_pkg::COEF_IDENTITY,
  parameter logic [8:0][gcm_pkg::COEF_W-1:0] PRESET_DAYLIGHT = gcm_pkg::COEF_IDENTITY,
  parameter logic [8:0][gcm_pkg::COEF_W-1:0] PRESET_D6500    = gcm_pkg::COEF_IDENTITY
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [gcm_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [gcm_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire gcm_pkg::gcm_rgb_s           s_pix,
  input  wire logic                        s_valid,
  output logic                             s_ready,
  output gcm_pkg::gcm_rgb_s                m_pix,
  output logic                             m_valid,
  input  wire logic                        m_ready,
  output gcm_pkg::gcm_illum_e              color_profile,
  output logic                             profile_load,
  output logic                             wb_neutral
);

  typedef struct packed {
    gcm_pkg::gcm_ctrl_s                      ctrl;
    gcm_pkg::gcm_illum_e                     illum;
    logic [gcm_pkg::EXP_W-1:0]               expo;
    logic [gcm_pkg::BLEND_W-1:0]             blend;
    logic [8:0][gcm_pkg::COEF_W-1:0]         coef;
    logic [gcm_pkg::ADDR_W-1:0]              awaddr;
    logic                                    aw_got;
    logic [31:0]                             wdata;
    logic [3:0]                              wstrb;
    logic                                    w_got;
    logic                                    bvalid;
    logic [1:0]                              bresp;
    logic                                    rvalid;
    logic [31:0]                             rdata;
    logic [1:0]                              rresp;
    logic                                    s1_valid;
    gcm_pkg::gcm_rgb_s                       s1_pix;
    logic                                    m_valid;
    gcm_pkg::gcm_rgb_s                       m_pix;
    logic [31:0]                             pixcnt;
    logic                                    profile_load;
  } gcm_state_s;

  gcm_state_s                        st_ff;
  gcm_state_s                        nxt_st;
  logic                              s2_ready;
  logic                              s1_ready;
  logic [gcm_pkg::PIX_W-1:0]         fs;
  logic                              matrix_on;
  logic                              blend_avail;
  logic [gcm_pkg::BLEND_W-1:0]       blend_eff;
  logic [8:0][gcm_pkg::COEF_W-1:0]   coef_sel;
  logic [gcm_pkg::EXP_W-1:0]         expo_eff;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = data[8*i +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic [gcm_pkg::PIX_W-1:0] sat(input logic signed [31:0] v,
                                                    input logic [gcm_pkg::PIX_W-1:0] top);
    logic [gcm_pkg::PIX_W-1:0] r;
    if (v < 0) begin
      r = '0;
    end else if (v > $signed({20'h00000, top})) begin
      r = top;
    end else begin
      r = v[gcm_pkg::PIX_W-1:0];
    end
    return r;
  endfunction

  // Piecewise-linear log2, 4.12 fixed point; caller discards the result for x of zero
  function automatic logic [15:0] log2_lin(input logic [gcm_pkg::PIX_W-1:0] x);
    logic [3:0]                p;
    logic [gcm_pkg::PIX_W-1:0] n;
    p = '0;
    for (int i = 0; i < gcm_pkg::PIX_W; i++) begin
      if (x[i]) begin
        p = 4'(i);
      end
    end
    n = x << (4'(gcm_pkg::PIX_W - 1) - p);
    return {p, n[gcm_pkg::PIX_W-2:0], 1'b0};
  endfunction

  // Inverse of log2_lin
  function automatic logic [23:0] exp2_lin(input logic [15:0] r);
    logic [23:0] m;
    m = 24'({1'b1, r[gcm_pkg::LOG_FRAC-1:0]}) << r[15:gcm_pkg::LOG_FRAC];
    return m >> gcm_pkg::LOG_FRAC;
  endfunction

  function automatic logic [gcm_pkg::PIX_W-1:0] curve(
      input logic [gcm_pkg::PIX_W-1:0] x,
      input logic [gcm_pkg::EXP_W-1:0] g,
      input logic [gcm_pkg::PIX_W-1:0] top);
    logic signed [16:0]        d;
    logic signed [36:0]        pr;
    logic signed [36:0]        r;
    logic [15:0]               lf;
    logic [23:0]               e;
    logic [gcm_pkg::PIX_W-1:0] y;
    lf = log2_lin(top);
    d  = $signed({1'b0, log2_lin(x)}) - $signed({1'b0, lf});
    pr = d * $signed({1'b0, g});
    r  = $signed({21'h0, lf}) + (pr >>> gcm_pkg::EXP_SHIFT);
    e  = exp2_lin(r[15:0]);
    if (x == '0) begin
      y = '0;
    end else if (x >= top) begin
      y = top;
    end else if (g == gcm_pkg::EXP_UNITY) begin
      y = x;
    end else if (r < 0) begin
      y = '0;
    end else begin
      y = sat($signed({8'h00, e}), top);
    end
    return y;
  endfunction

  function automatic logic [gcm_pkg::PIX_W-1:0] blended(
      input gcm_pkg::gcm_rgb_s               x,
      input logic [8:0][gcm_pkg::COEF_W-1:0] k,
      input logic [gcm_pkg::BLEND_W-1:0]     bl,
      input int                              row,
      input logic [gcm_pkg::PIX_W-1:0]       top);
    logic signed [31:0] acc;
    logic signed [31:0] mres;
    logic signed [31:0] diff;
    logic signed [49:0] pr;
    acc = '0;
    for (int j = 0; j < 3; j++) begin
      acc = acc + $signed(k[row*3+j]) * $signed({1'b0, x.c[j]});
    end
    mres = 32'(sat(acc >>> gcm_pkg::COEF_SHIFT, top));
    diff = mres - $signed({20'h00000, x.c[row]});
    pr   = diff * $signed({1'b0, bl});
    return sat($signed({20'h00000, x.c[row]}) +
               32'(pr >>> gcm_pkg::BLEND_SHIFT), top);
  endfunction

  assign fs          = st_ff.ctrl.out_12 ? gcm_pkg::FS_12 : gcm_pkg::FS_8;
  assign blend_avail = (st_ff.illum != gcm_pkg::ILL_OFF) &&
                       (st_ff.illum != gcm_pkg::ILL_CUSTOM);
  assign matrix_on   = (st_ff.illum != gcm_pkg::ILL_OFF) &&
                       !(st_ff.ctrl.raw_out && !st_ff.ctrl.enh_allow);
  assign blend_eff   = blend_avail ? st_ff.blend : gcm_pkg::BLEND_FULL;
  assign expo_eff    = st_ff.ctrl.curve_user ? st_ff.expo : gcm_pkg::EXP_DISPLAY;

  always_comb begin
    coef_sel = st_ff.coef;
    if (st_ff.illum == gcm_pkg::ILL_TUNGSTEN) begin
      coef_sel = PRESET_TUNGSTEN;
    end else if (st_ff.illum == gcm_pkg::ILL_DAYLIGHT) begin
      coef_sel = PRESET_DAYLIGHT;
    end else if (st_ff.illum == gcm_pkg::ILL_D6500) begin
      coef_sel = PRESET_D6500;
    end
  end

  assign s2_ready      = !st_ff.m_valid || m_ready;
  assign s1_ready      = !st_ff.s1_valid || s2_ready;
  assign s_ready       = s1_ready;
  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  assign m_pix         = st_ff.m_pix;
  assign m_valid       = st_ff.m_valid;
  assign color_profile = st_ff.illum;
  assign profile_load  = st_ff.profile_load;
  assign wb_neutral    = (st_ff.illum == gcm_pkg::ILL_CUSTOM);

  always_comb begin
    logic [gcm_pkg::ADDR_W-1:0] wa;
    logic [gcm_pkg::ADDR_W-1:0] ra;
    logic [31:0]                w;
    logic [3:0]                 idx;
    gcm_pkg::gcm_rgb_s          inp;
    wa  = '0;
    ra  = '0;
    w   = '0;
    idx = '0;
    inp = '0;
    nxt_st = st_ff;
    nxt_st.profile_load = 1'b0;

    // Write address and data, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Register write
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      wa = {st_ff.awaddr[gcm_pkg::ADDR_W-1:2], 2'b00};
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = gcm_pkg::RESP_OKAY;
      if (wa == gcm_pkg::A_CTRL) begin
        w = merge(32'(st_ff.ctrl), st_ff.wdata, st_ff.wstrb);
        nxt_st.ctrl = w[4:0];
      end else if (wa == gcm_pkg::A_ILLUM) begin
        w = merge(32'(st_ff.illum), st_ff.wdata, st_ff.wstrb);
        if (w[2:0] <= 3'(gcm_pkg::ILL_CUSTOM)) begin
          nxt_st.illum = gcm_pkg::gcm_illum_e'(w[2:0]);
          nxt_st.profile_load = (w[2:0] != 3'(st_ff.illum));
        end
      end else if (wa == gcm_pkg::A_EXPO) begin
        w = merge(32'(st_ff.expo), st_ff.wdata, st_ff.wstrb);
        nxt_st.expo = w[gcm_pkg::EXP_W-1:0];
      end else if (wa == gcm_pkg::A_BLEND) begin
        w = merge(32'(st_ff.blend), st_ff.wdata, st_ff.wstrb);
        if (blend_avail) begin
          nxt_st.blend = (w > 32'(gcm_pkg::BLEND_FULL)) ?
                         gcm_pkg::BLEND_FULL : w[gcm_pkg::BLEND_W-1:0];
        end
      end else if (wa >= gcm_pkg::A_COEF0 && wa <= gcm_pkg::A_COEF8) begin
        idx = 4'((wa - gcm_pkg::A_COEF0) >> 2);
        w = merge(32'(st_ff.coef[idx]), st_ff.wdata, st_ff.wstrb);
        nxt_st.coef[idx] = w[gcm_pkg::COEF_W-1:0];
      end else if (wa == gcm_pkg::A_STATUS || wa == gcm_pkg::A_PIXCNT) begin
        nxt_st.bresp = gcm_pkg::RESP_OKAY;
      end else begin
        nxt_st.bresp = gcm_pkg::RESP_SLVERR;
      end
    end

    // Register read
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      ra = {s_axi_araddr[gcm_pkg::ADDR_W-1:2], 2'b00};
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = gcm_pkg::RESP_OKAY;
      nxt_st.rdata  = '0;
      if (ra == gcm_pkg::A_CTRL) begin
        nxt_st.rdata[4:0] = st_ff.ctrl;
        nxt_st.rdata[gcm_pkg::CTRL_MTYPE_LSB +: 2] = gcm_pkg::MTYPE_RGB2RGB;
      end else if (ra == gcm_pkg::A_ILLUM) begin
        nxt_st.rdata[2:0] = st_ff.illum;
      end else if (ra == gcm_pkg::A_EXPO) begin
        nxt_st.rdata[gcm_pkg::EXP_W-1:0] = st_ff.expo;
      end else if (ra == gcm_pkg::A_BLEND) begin
        nxt_st.rdata[gcm_pkg::BLEND_W-1:0] = st_ff.blend;
      end else if (ra == gcm_pkg::A_STATUS) begin
        nxt_st.rdata[gcm_pkg::STAT_BLEND_AVAIL] = blend_avail;
        nxt_st.rdata[gcm_pkg::STAT_MATRIX_ON]   = matrix_on;
        nxt_st.rdata[gcm_pkg::STAT_WB_NEUTRAL]  = wb_neutral;
      end else if (ra == gcm_pkg::A_PIXCNT) begin
        nxt_st.rdata = st_ff.pixcnt;
      end else if (ra >= gcm_pkg::A_COEF0 && ra <= gcm_pkg::A_COEF8) begin
        idx = 4'((ra - gcm_pkg::A_COEF0) >> 2);
        nxt_st.rdata[gcm_pkg::COEF_W-1:0] = st_ff.coef[idx];
      end else begin
        nxt_st.rresp = gcm_pkg::RESP_SLVERR;
      end
    end

    // Stage 1: clamp input, matrix and blend
    if (s1_ready) begin
      nxt_st.s1_valid = s_valid;
      if (s_valid) begin
        for (int i = 0; i < 3; i++) begin
          inp.c[i] = sat($signed({20'h00000, s_pix.c[i]}), fs);
        end
        for (int i = 0; i < 3; i++) begin
          nxt_st.s1_pix.c[i] = matrix_on ?
                               blended(inp, coef_sel, blend_eff, i, fs) : inp.c[i];
        end
      end
    end

    // Stage 2: brightness curve
    if (s2_ready) begin
      nxt_st.m_valid = st_ff.s1_valid;
      if (st_ff.s1_valid) begin
        for (int i = 0; i < 3; i++) begin
          nxt_st.m_pix.c[i] = st_ff.ctrl.curve_on ?
                              curve(st_ff.s1_pix.c[i], expo_eff, fs) :
                              st_ff.s1_pix.c[i];
        end
      end
    end
    if (st_ff.m_valid && m_ready) begin
      nxt_st.pixcnt = st_ff.pixcnt + 32'h00000001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff       <= '0;
      st_ff.expo  <= gcm_pkg::EXP_UNITY;
      st_ff.blend <= gcm_pkg::BLEND_FULL;
      st_ff.coef  <= gcm_pkg::COEF_IDENTITY;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// File: verif/gcm_stage_assertions.sv
/*
  Port checker of the curve and colour-matrix stage.
  Assumes the single aclk domain with aresetn; bound into gcm_stage.
*/
module gcm_stage_assertions (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic                 s_valid,
  input wire logic                 s_ready,
  input wire gcm_pkg::gcm_rgb_s    m_pix,
  input wire logic                 m_valid,
  input wire logic                 m_ready,
  input wire gcm_pkg::gcm_illum_e  color_profile,
  input wire logic                 profile_load,
  input wire logic                 wb_neutral
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_pipe_latency: assert property (s_valid && s_ready ##1 (m_ready || !m_valid) |=> m_valid)
    else $error("pixel not out in two cycles");
  chk_out_hold: assert property (m_valid && !m_ready |=> m_valid && $stable(m_pix))
    else $error("output pixel dropped");
  chk_neutral_custom: assert property (wb_neutral == (color_profile == gcm_pkg::ILL_CUSTOM))
    else $error("neutral profile mismatch");
  chk_profile_pulse: assert property ($changed(color_profile) |-> ##[0:1] profile_load)
    else $error("profile load missing");
  chk_load_cause: assert property (profile_load |-> $changed(color_profile))
    else $error("profile load without change");

  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_stall: cover property (m_valid && !m_ready);
  cov_custom: cover property (wb_neutral && m_valid && m_ready);
endmodule

bind gcm_stage gcm_stage_assertions chk_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_valid(s_valid), .s_ready(s_ready), .m_pix(m_pix),
  .m_valid(m_valid), .m_ready(m_ready), .color_profile(color_profile),
  .profile_load(profile_load), .wb_neutral(wb_neutral));

// File: verif/gcm_sink.sv
/*
  Downstream pixel sink that stalls one cycle in three and queues output.
  Assumes the stage's aclk and aresetn.
*/
module gcm_sink (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire gcm_pkg::gcm_rgb_s  m_pix,
  input wire logic               m_valid,
  output logic                   m_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  gcm_pkg::gcm_rgb_s got[$];
  logic [1:0]        cnt_ff;

  // Stall pattern and capture on handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff  <= 2'h0;
      m_ready <= 1'b0;
    end else begin
      cnt_ff  <= (cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
      m_ready <= (cnt_ff != 2'h2);
      if (m_valid && m_ready) got.push_back(m_pix);
    end
  end
endmodule

// File: verif/gcm_stage_tb.sv
/*
  Register and pixel tests of the curve and colour-matrix stage.
  Assumes gcm_stage, the gcm_sink partner and the bound checker.
*/
module gcm_stage_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [8:0][8:0] SWAP = {9'h020, 9'h000, 9'h000, 9'h000, 9'h000, 9'h020,
                                      9'h000, 9'h020, 9'h000};
  localparam logic [8:0][8:0] CUST = {9'h1e0, 9'h000, 9'h000, 9'h000, 9'h000, 9'h020,
                                      9'h000, 9'h0ff, 9'h000};
  logic                aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]          awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]         wdata = 32'h0;
  logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                arvalid = 1'b0, rready = 1'b0, s_valid = 1'b0;
  logic                awready, wready, bvalid, arready, rvalid, s_ready, m_valid, m_ready;
  logic                profile_load, wb_neutral;
  logic [1:0]          bresp, rresp;
  logic [31:0]         rdata;
  gcm_pkg::gcm_rgb_s   s_pix = '0;
  gcm_pkg::gcm_rgb_s   m_pix;
  gcm_pkg::gcm_illum_e color_profile;
  int                  errors = 0, checks = 0, cyc = 0;

  gcm_stage #(.PRESET_TUNGSTEN(SWAP), .PRESET_D6500(SWAP)) gcm_stage_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_pix(s_pix), .s_valid(s_valid), .s_ready(s_ready), .m_pix(m_pix), .m_valid(m_valid),
    .m_ready(m_ready), .color_profile(color_profile), .profile_load(profile_load),
    .wb_neutral(wb_neutral));
  gcm_sink gcm_sink_inst (.aclk(aclk), .aresetn(aresetn), .m_pix(m_pix), .m_valid(m_valid),
    .m_ready(m_ready));

  always #12.5 aclk = ~aclk;

  task automatic chk(input string n, input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = gcm_pkg::RESP_OKAY);
    logic       ha, hw, hb;
    logic [1:0] r;
    hb = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      r  = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", r, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er = gcm_pkg::RESP_OKAY);
    logic        ha, hr;
    logic [31:0] d;
    logic [1:0]  r;
    hr = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk("rdata", d, ed);
    chk("rresp", r, er);
  endtask

  task automatic px(input logic [11:0] r, g, b, er, eg, eb);
    logic              h;
    int                n;
    gcm_pkg::gcm_rgb_s o;
    h = 1'b0;
    n = 0;
    @(posedge aclk);
    s_pix   <= {b, g, r};
    s_valid <= 1'b1;
    while (!h) begin
      @(negedge aclk);
      h = s_ready;
      @(posedge aclk);
    end
    s_valid <= 1'b0;
    while (gcm_sink_inst.got.size() == 0 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    o = 'x;
    if (gcm_sink_inst.got.size() > 0) o = gcm_sink_inst.got.pop_front();
    chk("pixel", o, {eb, eg, er});
  endtask

  task test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      test_done;
    end
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(gcm_pkg::A_CTRL, 32'h0);
    rd(gcm_pkg::A_ILLUM, 32'h0);
    rd(gcm_pkg::A_EXPO, 32'h10000);
    rd(gcm_pkg::A_BLEND, 32'h10000);
    rd(gcm_pkg::A_COEF0, 32'h20);
    rd(gcm_pkg::A_STATUS, 32'h0);
    rd(8'h80, 32'h0, gcm_pkg::RESP_SLVERR);
    wr(8'h80, 32'h0, gcm_pkg::RESP_SLVERR);
    wr(gcm_pkg::A_CTRL, 32'h313);
    rd(gcm_pkg::A_CTRL, 32'h13);
    px(0, 1234, 4095, 0, 1234, 4095);
    wr(gcm_pkg::A_EXPO, 32'h0);
    px(0, 1, 4095, 0, 4095, 4095);
    wr(gcm_pkg::A_EXPO, 32'h3ffff);
    rd(gcm_pkg::A_EXPO, 32'h3ffff);
    px(0, 4095, 0, 0, 4095, 0);
    wr(gcm_pkg::A_CTRL, 32'h01);
    px(0, 255, 300, 0, 255, 255);
    wr(gcm_pkg::A_CTRL, 32'h10);
    px(0, 1, 4095, 0, 1, 4095);
    wr(gcm_pkg::A_ILLUM, 32'h1);
    chk("profile", color_profile, 36'h1);
    rd(gcm_pkg::A_STATUS, 32'h3);
    wr(gcm_pkg::A_BLEND, 32'h0);
    px(100, 200, 300, 100, 200, 300);
    wr(gcm_pkg::A_BLEND, 32'h8000);
    px(100, 200, 300, 150, 150, 300);
    wr(gcm_pkg::A_BLEND, 32'h1ffff);
    rd(gcm_pkg::A_BLEND, 32'h10000);
    px(100, 200, 300, 200, 100, 300);
    wr(gcm_pkg::A_ILLUM, 32'h5);
    rd(gcm_pkg::A_ILLUM, 32'h1);
    wr(gcm_pkg::A_ILLUM, 32'h4);
    rd(gcm_pkg::A_STATUS, 32'h6);
    chk("neutral", wb_neutral, 36'h1);
    wr(gcm_pkg::A_BLEND, 32'h4000);
    rd(gcm_pkg::A_BLEND, 32'h10000);
    for (int i = 0; i < 9; i++) begin
      wr(gcm_pkg::A_COEF0 + 8'(4 * i), {23'h0, CUST[i]});
    end
    px(10, 4000, 300, 4095, 10, 0);
    wr(gcm_pkg::A_CTRL, 32'h18);
    px(10, 4000, 300, 10, 4000, 300);
    wr(gcm_pkg::A_CTRL, 32'h1c);
    px(10, 4000, 300, 4095, 10, 0);
    wr(gcm_pkg::A_ILLUM, 32'h2);
    px(10, 4000, 300, 10, 4000, 300);
    wr(gcm_pkg::A_ILLUM, 32'h3);
    px(10, 4000, 300, 4000, 10, 300);
    wr(gcm_pkg::A_ILLUM, 32'h0);
    px(10, 4000, 300, 10, 4000, 300);
    wr(gcm_pkg::A_PIXCNT, 32'h0);
    rd(gcm_pkg::A_PIXCNT, 32'he);
    test_done;
  end
endmodule
